// ==== fpdr_top.sv ====
// Deep power-down resume and hold control of the serial flash interface
`timescale 1ns/1ps
`include "fpdr_params.svh"
module fpdr_top
   import fpdr_pkg::*;
(
   // System clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Serial link pins
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_si_i,
   input wire logic hold_n_i,
   input wire logic wp_n_i,
   output logic spi_so_o,
   output logic spi_so_oe_o,
   // Device core side
   input wire logic busy_i,
   input wire logic wel_set_i,
   input wire logic so_data_i,
   input wire logic so_drive_i,
   output logic cmd_valid_o,
   output logic [7:0] cmd_byte_o,
   output logic abort_o,
   output logic wel_o,
   output logic wp_active_o,
   // Status
   output logic standby_o,
   output logic deep_pd_o,
   output logic hold_o
);

   // Match of a received byte against an opcode
   function automatic logic fpdr_match(
      input fpdr_byte_t b,
      input fpdr_byte_t op
   );
      fpdr_match = (b == op);
   endfunction

   // ------------------------------------------------------------------
   // Link domain, clocked by the serial clock; counter and flags cleared by chip select
   // ------------------------------------------------------------------
   logic [`FPDR_BIT_CNT_W-1:0] bit_cnt_ff;
   logic [`FPDR_BIT_CNT_W-1:0] nxt_bit_cnt;
   logic [6:0] shift_ff;
   fpdr_byte_t op_ff;
   logic op_done_ff;
   logic mid_byte_ff;

   assign nxt_bit_cnt = bit_cnt_ff + `FPDR_BIT_CNT_W'(1);

   // Bit counter and progress flags
   always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
      if (spi_cs_n_i) begin
         bit_cnt_ff <= `FPDR_BIT_CNT_RST;
         op_done_ff <= 1'b0;
         mid_byte_ff <= 1'b0;
      // [R11] Paused edges ignored
      end else if (hold_n_i) begin
         bit_cnt_ff <= nxt_bit_cnt;
         mid_byte_ff <= (nxt_bit_cnt != `FPDR_BIT_CNT_RST);
         if (bit_cnt_ff == 3'h7) begin
            op_done_ff <= 1'b1;
         end
      end
   end

   // Data path has no reset; it is only read once qualified
   always_ff @(posedge spi_sck_i) begin
      if (!spi_cs_n_i && hold_n_i) begin
         shift_ff <= {shift_ff[5:0], spi_si_i};
      end
   end

   // Opcode is the first byte only
   always_ff @(posedge spi_sck_i) begin
      // [R3] Later bytes ignored
      if (!spi_cs_n_i && hold_n_i && !op_done_ff &&
          bit_cnt_ff == 3'h7) begin
         op_ff <= {shift_ff, spi_si_i};
      end
   end

   // ------------------------------------------------------------------
   // Crossing into the system domain
   // ------------------------------------------------------------------
   logic [`FPDR_SYNC_W-1:0] sync_in;
   logic [`FPDR_SYNC_W-1:0] sync_out;
   logic cs_n_s;
   logic sck_s;
   logic hold_n_s;
   logic wp_n_s;
   logic op_done_s;
   logic mid_byte_s;

   assign sync_in[`FPDR_SY_CS] = spi_cs_n_i;
   assign sync_in[`FPDR_SY_SCK] = spi_sck_i;
   assign sync_in[`FPDR_SY_HOLD] = hold_n_i;
   assign sync_in[`FPDR_SY_WP] = wp_n_i;
   assign sync_in[`FPDR_SY_DONE] = op_done_ff;
   assign sync_in[`FPDR_SY_MID] = mid_byte_ff;

   fpdr_sync #(
      .W(`FPDR_SYNC_W)
   ) u_sync (
      .clk_i(clk_sys_i),
      .srst_i(srst_i),
      .async_i(sync_in),
      .sync_o(sync_out)
   );

   assign cs_n_s = sync_out[`FPDR_SY_CS];
   assign sck_s = sync_out[`FPDR_SY_SCK];
   assign hold_n_s = sync_out[`FPDR_SY_HOLD];
   assign wp_n_s = sync_out[`FPDR_SY_WP];
   assign op_done_s = sync_out[`FPDR_SY_DONE];
   assign mid_byte_s = sync_out[`FPDR_SY_MID];

   // ------------------------------------------------------------------
   // Frame tracking in the system domain
   // ------------------------------------------------------------------
   logic cs_n_q_ff;
   logic op_done_q_ff;
   logic mid_q1_ff;
   logic mid_q2_ff;
   logic op_got_ff;
   fpdr_byte_t op_byte_ff;
   logic cs_rise;
   logic op_rise;
   logic frame_whole;

   assign cs_rise = cs_n_s & ~cs_n_q_ff;
   assign op_rise = op_done_s & ~op_done_q_ff & ~cs_n_s;

   // Edge history
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cs_n_q_ff <= 1'b1;
         // Same level as the synchroniser reset, no false rise
         op_done_q_ff <= 1'b1;
      end else begin
         cs_n_q_ff <= cs_n_s;
         op_done_q_ff <= op_done_s;
      end
   end

   // Alignment history; two cycles back covers sync skew at the rise
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mid_q1_ff <= 1'b0;
         mid_q2_ff <= 1'b0;
      end else begin
         mid_q1_ff <= mid_byte_s;
         mid_q2_ff <= mid_byte_s | mid_q1_ff;
      end
   end

   // Opcode capture; the link byte is stable once its flag is seen
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         op_got_ff <= 1'b0;
         op_byte_ff <= `FPDR_BYTE_RST;
      end else if (op_rise) begin
         op_got_ff <= 1'b1;
         op_byte_ff <= op_ff;
      end else if (cs_rise) begin
         op_got_ff <= 1'b0;
      end
   end

   // [R6] Whole opcode, byte aligned
   assign frame_whole = op_got_ff & ~mid_q2_ff;

   // ------------------------------------------------------------------
   // Pause tracking
   // ------------------------------------------------------------------
   logic hold_ff;
   logic held_at_end;

   // Pause state follows the pin only while the clock is low; select high clears it in either phase
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         hold_ff <= 1'b0;
      // [R8] Select high cancels
      end else if (cs_n_s) begin
         hold_ff <= 1'b0;
      // [R9] Start in low phase
      // [R13] End in low phase
      end else if (!sck_s) begin
         hold_ff <= ~hold_n_s;
      end
      // [R10] Held through high phase
   end

   assign held_at_end = cs_rise & (hold_ff | ~hold_n_s);

   // ------------------------------------------------------------------
   // Power state machine
   // ------------------------------------------------------------------
   fpdr_state_e state_ff;
   fpdr_cnt_t cnt_ff;
   logic go_sleep;
   logic go_wake;
   logic cnt_end;

   // [R16] Sleep frame check
   // [R7] Busy core not paused
   assign go_sleep = cs_rise & frame_whole & ~held_at_end & ~busy_i &
                     fpdr_match(op_byte_ff, `FPDR_OP_SLEEP);
   // [R2] Resume opcode match
   assign go_wake = cs_rise & frame_whole & ~held_at_end &
                    fpdr_match(op_byte_ff, `FPDR_OP_RESUME);

   assign cnt_end =
      (state_ff == FPDR_ST_ENTER &&
       cnt_ff == `FPDR_CNT_W'(`FPDR_SLEEP_ENTRY_CYC - 1)) ||
      (state_ff == FPDR_ST_WAKE &&
       cnt_ff == `FPDR_CNT_W'(`FPDR_RESUME_WAKE_CYC -
                              `FPDR_WAKE_PIPE_CYC - 1));

   // State transitions
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         // [R17] Reset to standby
         state_ff <= FPDR_ST_STANDBY;
      end else begin
         case (state_ff)
            FPDR_ST_STANDBY: begin
               if (go_sleep) begin
                  state_ff <= FPDR_ST_ENTER;
               end
            end
            FPDR_ST_ENTER: begin
               if (cnt_end) begin
                  state_ff <= FPDR_ST_DEEP;
               end
            end
            FPDR_ST_DEEP: begin
               // [R1] Only resume decoded
               // [R4] Leave on select rise
               if (go_wake) begin
                  state_ff <= FPDR_ST_WAKE;
               end
            end
            FPDR_ST_WAKE: begin
               // [R15] Standby within wake time
               if (cnt_end) begin
                  state_ff <= FPDR_ST_STANDBY;
               end
            end
            default: begin
               state_ff <= FPDR_ST_STANDBY;
            end
         endcase
      end
   end

   // Entry and wake timer
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cnt_ff <= `FPDR_CNT_RST;
      end else if (state_ff == FPDR_ST_ENTER ||
                   state_ff == FPDR_ST_WAKE) begin
         if (cnt_end) begin
            cnt_ff <= `FPDR_CNT_RST;
         end else begin
            cnt_ff <= cnt_ff + `FPDR_CNT_W'(1);
         end
      end else begin
         cnt_ff <= `FPDR_CNT_RST;
      end
   end

   // ------------------------------------------------------------------
   // Core side outputs
   // ------------------------------------------------------------------
   logic wel_ff;
   logic nxt_wel;

   // Commands reach the core only from standby
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cmd_valid_o <= 1'b0;
         cmd_byte_o <= `FPDR_BYTE_RST;
      end else begin
         // [R5] Forward in standby
         cmd_valid_o <= op_rise && state_ff == FPDR_ST_STANDBY;
         if (op_rise) begin
            cmd_byte_o <= op_ff;
         end
      end
   end

   // Abort of the started operation
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         abort_o <= 1'b0;
      end else begin
         // [R14] Select rise while paused
         abort_o <= held_at_end;
      end
   end

   // Set from the core wins over the abort clear
   always_comb begin
      nxt_wel = wel_ff;
      if (wel_set_i) begin
         nxt_wel = 1'b1;
      // [R14] Latch flag cleared
      end else if (held_at_end) begin
         nxt_wel = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wel_ff <= 1'b0;
      end else begin
         wel_ff <= nxt_wel;
      end
   end

   assign wel_o = wel_ff;

   // Write guard is followed whatever the pause does
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wp_active_o <= 1'b0;
      end else begin
         // [R12] Guard tracked while paused
         wp_active_o <= ~wp_n_s;
      end
   end

   // ------------------------------------------------------------------
   // Serial output; enable lags a select pin change by three system cycles, a pause pin change by four
   // ------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         spi_so_o <= 1'b0;
         spi_so_oe_o <= 1'b0;
      end else begin
         spi_so_o <= so_data_i;
         // [R11] Output floats when paused
         // [R1] No answers in power-down
         spi_so_oe_o <= so_drive_i & ~cs_n_s & ~hold_ff &
                        (state_ff == FPDR_ST_STANDBY);
      end
   end

   // Status
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         standby_o <= 1'b1;
         deep_pd_o <= 1'b0;
         hold_o <= 1'b0;
      end else begin
         standby_o <= (state_ff == FPDR_ST_STANDBY);
         deep_pd_o <= (state_ff == FPDR_ST_DEEP);
         hold_o <= hold_ff;
      end
   end

endmodule // fpdr_top

// ==== fpdr_params.svh ====
// Constants for the deep power-down resume and hold control block
// Function
// [R1] Deep power-down accepts only the resume opcode
// [R2] Resume opcode is ABh after chip select
// [R3] Bits after the resume opcode are ignored
// [R4] Chip select rise leaves deep power-down
// [R5] Standby again forwards ordinary commands
// [R6] Partial or misaligned frame keeps deep power-down
// [R7] Pause never stops self-timed program or erase
// [R8] Pause only while chip select is asserted
// [R9] Pause starts in a clock-low phase
// [R10] Pause lasts while pause and select asserted
// [R11] Paused: output floats, clock and input ignored
// [R12] Write-guard input still followed while paused
// [R13] Pause ends in a clock-low phase
// [R14] Select rise while paused aborts, clears latch
// [R15] Wake time at most 30 microseconds
// [R16] Opcode B9h in own frame enters power-down
// [R17] Reset leaves the device in standby
`ifndef FPDR_PARAMS_SVH
`define FPDR_PARAMS_SVH

// Opcodes
`define FPDR_OP_RESUME 8'hab
`define FPDR_OP_SLEEP 8'hb9

// Clock of the control domain
`define FPDR_CLK_PERIOD_NS 8

// Timing, printed figures and derived cycle counts (maxima round down)
`define FPDR_RESUME_WAKE_TIME_US 30
`define FPDR_SLEEP_ENTRY_TIME_US 3
`define FPDR_RESUME_WAKE_CYC \
   ((`FPDR_RESUME_WAKE_TIME_US * 1000) / `FPDR_CLK_PERIOD_NS)
`define FPDR_SLEEP_ENTRY_CYC \
   ((`FPDR_SLEEP_ENTRY_TIME_US * 1000) / `FPDR_CLK_PERIOD_NS)
// Pin to status latency, taken out of the wake budget
`define FPDR_WAKE_PIPE_CYC 4

// Field positions and widths
`define FPDR_BIT_CNT_W 3
`define FPDR_CNT_W 12
`define FPDR_SYNC_W 6
`define FPDR_SY_CS 0
`define FPDR_SY_SCK 1
`define FPDR_SY_HOLD 2
`define FPDR_SY_WP 3
`define FPDR_SY_DONE 4
`define FPDR_SY_MID 5

// Reset values
`define FPDR_CNT_RST 12'h000
`define FPDR_BYTE_RST 8'h00
`define FPDR_BIT_CNT_RST 3'h0

`endif

// ==== fpdr_pkg.sv ====
// Types shared by the deep power-down resume and hold control block
package fpdr_pkg;

   // Gray coded along standby, entry, deep, wake
   typedef enum logic [1:0] {
      FPDR_ST_STANDBY = 2'b00,
      FPDR_ST_ENTER = 2'b01,
      FPDR_ST_DEEP = 2'b11,
      FPDR_ST_WAKE = 2'b10
   } fpdr_state_e;

   typedef logic [7:0] fpdr_byte_t;
   typedef logic [11:0] fpdr_cnt_t;

endpackage

// ==== fpdr_sync.sv ====
// Two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module fpdr_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Levels
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_lane
         // First stage feeds only the second
         always_ff @(posedge clk_i) begin
            if (srst_i) begin
               meta_ff[g] <= 1'b1;
               sync_ff[g] <= 1'b1;
            end else begin
               meta_ff[g] <= async_i[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign sync_o = sync_ff;

endmodule // fpdr_sync

// ==== fpdr_top_assertions.sv ====
// Concurrent checks on the resume and hold control ports
`timescale 1ns/1ps
module fpdr_top_assertions (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // Pins and core side
   input wire logic spi_cs_n_i,
   input wire logic wp_n_i,
   input wire logic wel_set_i,
   // Outputs watched
   input wire logic spi_so_oe_o,
   input wire logic cmd_valid_o,
   input wire logic abort_o,
   input wire logic wel_o,
   input wire logic wp_active_o,
   input wire logic standby_o,
   input wire logic deep_pd_o,
   input wire logic hold_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic waking_ff;
   logic [12:0] wake_cnt_ff;
   // Entry also shows both states low, so arm on deep only
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || standby_o) begin
         waking_ff <= 1'b0;
      end else if (deep_pd_o) begin
         waking_ff <= 1'b1;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || deep_pd_o || !waking_ff || standby_o) begin
         wake_cnt_ff <= 13'h0000;
      end else begin
         wake_cnt_ff <= wake_cnt_ff + 13'h0001;
      end
   end
   AST_CMD_STANDBY: assert property (cmd_valid_o |-> standby_o)
      else $error("opcode forwarded outside standby");
   AST_ONE_STATE: assert property (!(standby_o && deep_pd_o))
      else $error("standby and deep together");
   // Pin to deep fall takes up to four of the 3750 cycles
   AST_WAKE_TIME: assert property (wake_cnt_ff <= 13'hea2)
      else $error("wake took too long");
   AST_ENTRY_TIME: assert property (
      $fell(standby_o) |-> ##[1:380] deep_pd_o)
      else $error("entry took too long");
   AST_HOLD_SO_OFF: assert property (
      hold_o && $past(hold_o) |-> !spi_so_oe_o)
      else $error("output driven while paused");
   AST_NO_HOLD_CS_HIGH: assert property (spi_cs_n_i [*8] |-> !hold_o)
      else $error("paused without select");
   AST_ABORT_WEL: assert property (
      abort_o && !$past(wel_set_i) |-> !wel_o)
      else $error("latch kept after abort");
   AST_WEL_SET: assert property (wel_set_i |=> wel_o)
      else $error("latch not set");
   AST_WP_FOLLOW: assert property ((!wp_n_i) [*5] |-> wp_active_o)
      else $error("write guard not followed");
   AST_RESET_STANDBY: assert property (
      $fell(srst_i) |-> standby_o && !deep_pd_o && !hold_o)
      else $error("not in standby after reset");
endmodule // fpdr_top_assertions

bind fpdr_top fpdr_top_assertions u_chk (
   .clk_sys_i(clk_sys_i),
   .srst_i(srst_i),
   .spi_cs_n_i(spi_cs_n_i),
   .wp_n_i(wp_n_i),
   .wel_set_i(wel_set_i),
   .spi_so_oe_o(spi_so_oe_o),
   .cmd_valid_o(cmd_valid_o),
   .abort_o(abort_o),
   .wel_o(wel_o),
   .wp_active_o(wp_active_o),
   .standby_o(standby_o),
   .deep_pd_o(deep_pd_o),
   .hold_o(hold_o)
);

// ==== fpdr_host.sv ====
// Host controller model driving the serial link in mode 0
`timescale 1ns/1ps
module fpdr_host (
   // Link pins
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o,
   output logic hold_n_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
      hold_n_o = 1'b1;
   end
   // Clock runs only inside frames and idles low
   task automatic pulse();
      #15 sck_o = 1'b1;
      #15 sck_o = 1'b0;
   endtask
   task automatic shift(input logic [15:0] d, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         si_o = d[i];
         pulse();
      end
   endtask
   // garbage bits that a paused device must drop
   task automatic noise(input int n);
      repeat (n) begin
         si_o = 1'($urandom);
         pulse();
      end
   endtask
   task automatic frame_start();
      cs_n_o = 1'b0;
      #10;
   endtask
   // pause moved only while the clock is low
   task automatic pause(input logic on);
      #5 hold_n_o = !on;
      #5;
   endtask
   // Released data shows the inverse; gap above 50 ns
   task automatic frame_end();
      #10 cs_n_o = 1'b1;
      si_o = !si_o;
      #60;
   endtask
endmodule // fpdr_host

// ==== fpdr_top_bench.sv ====
// Self-checking bench of the resume and hold control block
`timescale 1ns/1ps
`include "fpdr_params.svh"
module fpdr_top_bench
   import fpdr_pkg::*;
;
   logic clk_sys_i = 1'b0;
   logic srst_i;
   logic busy_i;
   logic wel_set_i;
   logic so_data_i;
   logic so_drive_i;
   logic wp_n_i;
   logic so_bit;
   wire spi_sck_i;
   wire spi_cs_n_i;
   wire spi_si_i;
   wire hold_n_i;
   logic spi_so_o;
   logic spi_so_oe_o;
   logic cmd_valid_o;
   logic [7:0] cmd_byte_o;
   logic abort_o;
   logic wel_o;
   logic wp_active_o;
   logic standby_o;
   logic deep_pd_o;
   logic hold_o;
   int miscompares = 0;
   int checked = 0;
   int abort_exp = 0;
   fpdr_byte_t exp_q[$];
   fpdr_byte_t b;

   always #4 clk_sys_i = ~clk_sys_i;

   fpdr_top dut (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .spi_sck_i(spi_sck_i),
      .spi_cs_n_i(spi_cs_n_i),
      .spi_si_i(spi_si_i),
      .hold_n_i(hold_n_i),
      .wp_n_i(wp_n_i),
      .spi_so_o(spi_so_o),
      .spi_so_oe_o(spi_so_oe_o),
      .busy_i(busy_i),
      .wel_set_i(wel_set_i),
      .so_data_i(so_data_i),
      .so_drive_i(so_drive_i),
      .cmd_valid_o(cmd_valid_o),
      .cmd_byte_o(cmd_byte_o),
      .abort_o(abort_o),
      .wel_o(wel_o),
      .wp_active_o(wp_active_o),
      .standby_o(standby_o),
      .deep_pd_o(deep_pd_o),
      .hold_o(hold_o)
   );
   fpdr_host host (.sck_o(spi_sck_i), .cs_n_o(spi_cs_n_i),
      .si_o(spi_si_i), .hold_n_o(hold_n_i));

   task automatic chk_bit(input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: level %b, expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_byte(input fpdr_byte_t exp, input fpdr_byte_t got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: opcode %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Compares %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic send(input logic [15:0] d, input int n);
      host.frame_start();
      host.shift(d, n);
      host.frame_end();
   endtask

   // Results are matched against the oldest note, mid-cycle
   always @(negedge clk_sys_i) begin
      if (cmd_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk_bit(1'b0, 1'b1);
         end else begin
            chk_byte(exp_q.pop_front(), cmd_byte_o);
         end
      end
      if (abort_o === 1'b1) begin
         chk_bit(1'b1, abort_exp > 0);
         abort_exp = 0;
      end
   end

   // Whole run is about 5.3k cycles
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      srst_i = 1'b1;
      busy_i = 1'b0;
      wel_set_i = 1'b0;
      so_data_i = 1'b0;
      so_drive_i = 1'b0;
      wp_n_i = 1'b1;
      void'($urandom(17));
      cyc(12);
      srst_i = 1'b0;
      cyc(4);
      chk_bit(1'b1, standby_o);
      exp_q.push_back(8'h03);
      send(16'h0003, 8);
      cyc(10);
      // Busy core keeps the sleep request out
      busy_i = 1'b1;
      exp_q.push_back(`FPDR_OP_SLEEP);
      send({8'h00, `FPDR_OP_SLEEP}, 8);
      cyc(400);
      chk_bit(1'b0, deep_pd_o);
      busy_i = 1'b0;
      exp_q.push_back(`FPDR_OP_SLEEP);
      send({`FPDR_OP_SLEEP, 8'h5a}, 16);
      cyc(400);
      chk_bit(1'b1, deep_pd_o);
      so_drive_i = 1'b1;
      // Status read gets no answer in power-down
      host.frame_start();
      host.shift(16'h0005, 8);
      chk_bit(1'b0, spi_so_oe_o);
      host.frame_end();
      for (int i = 0; i < 5; i++) begin
         b = 8'($urandom);
         if (b == `FPDR_OP_RESUME) begin
            b = 8'h00;
         end
         send({8'h00, b}, 8);
      end
      cyc(10);
      chk_bit(1'b1, deep_pd_o);
      send(16'h0055, 7);
      send({4'h0, `FPDR_OP_RESUME, 4'ha}, 12);
      cyc(10);
      chk_bit(1'b1, deep_pd_o);
      send({`FPDR_OP_RESUME, 8'hff}, 16);
      cyc(3760);
      chk_bit(1'b1, standby_o);
      exp_q.push_back(8'h9c);
      @(negedge clk_sys_i);
      so_drive_i = 1'b1;
      host.frame_start();
      host.shift(16'h0009, 4);
      chk_bit(1'b1, spi_so_oe_o);
      host.pause(1'b1);
      host.noise(3);
      chk_bit(1'b1, hold_o);
      chk_bit(1'b0, spi_so_oe_o);
      @(negedge clk_sys_i);
      wp_n_i = 1'b0;
      so_bit = 1'($urandom);
      so_data_i = so_bit;
      cyc(6);
      chk_bit(1'b1, wp_active_o);
      chk_bit(so_bit, spi_so_o);
      wp_n_i = 1'b1;
      host.noise(2);
      chk_bit(1'b1, hold_o);
      host.pause(1'b0);
      host.shift(16'h000c, 4);
      host.frame_end();
      cyc(6);
      chk_bit(1'b0, hold_o);
      chk_bit(1'b0, wp_active_o);
      wel_set_i = 1'b1;
      cyc(1);
      wel_set_i = 1'b0;
      cyc(1);
      chk_bit(1'b1, wel_o);
      exp_q.push_back(8'h06);
      host.frame_start();
      host.shift(16'h0006, 8);
      host.pause(1'b1);
      abort_exp = 1;
      host.frame_end();
      cyc(10);
      chk_bit(1'b0, wel_o);
      chk_bit(1'b1, abort_exp == 0);
      cyc(8);
      chk_bit(1'b0, hold_o);
      host.pause(1'b0);
      chk_bit(1'b1, exp_q.size() == 0);
      report_and_stop();
   end
endmodule // fpdr_top_bench
